// ===== rtl/dvr_ramp.v
// digital volume ramp controller with avalon-mm register slave
// assumes fs_tick pulses once per sample period, inputs synchronous to mclk
//
// Chosen here: the Avalon-MM slave port.
`include "dvr_defs.vh"
module dvr_ramp
#(
    parameter VOL_W = 8
)
(
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    // avalon-mm slave
    input  wire [7:0]       address,
    input  wire             read,
    input  wire             write,
    input  wire [31:0]      writedata,
    input  wire [3:0]       byteenable,
    output reg  [31:0]      readdata,
    output reg              waitrequest,
    output reg  [1:0]       response,
    // audio side
    input  wire             fs_tick,
    input  wire             soft_mute_pin_n,
    input  wire             emergency,
    output reg  [VOL_W-1:0] volume
);
    localparam ST_IDLE = 2'h0;
    localparam ST_DOWN = 2'h1;
    localparam ST_UP   = 2'h2;
    // avalon response codes
    localparam RESP_OK  = 2'h0;
    localparam RESP_ERR = 2'h2;

    reg  [7:0]       normal_volume_ramp_config;
    reg  [7:0]       emergency_volume_ramp_config;
    reg              soft_mute_bit;
    reg  [VOL_W-1:0] target_volume;
    reg  [1:0]       state;
    reg  [2:0]       period_cnt;
    reg              accessed;

    wire [2:0]       nd_per;
    wire [7:0]       nd_step;
    wire [2:0]       nu_per;
    wire [7:0]       nu_step;
    wire [2:0]       ed_per;
    wire [7:0]       ed_step;

    dvr_step u_nd
    (
        .interval_code (normal_volume_ramp_config[`DVR_NDF_HI:`DVR_NDF_LO]),
        .step_code     (normal_volume_ramp_config[`DVR_NDS_HI:`DVR_NDS_LO]),
        .period_max    (nd_per),
        .step_codes    (nd_step)
    );
    dvr_step u_nu
    (
        .interval_code (normal_volume_ramp_config[`DVR_NUF_HI:`DVR_NUF_LO]),
        .step_code     (normal_volume_ramp_config[`DVR_NUS_HI:`DVR_NUS_LO]),
        .period_max    (nu_per),
        .step_codes    (nu_step)
    );
    dvr_step u_ed
    (
        .interval_code (emergency_volume_ramp_config[`DVR_EDF_HI:`DVR_EDF_LO]),
        .step_code     (emergency_volume_ramp_config[`DVR_EDS_HI:`DVR_EDS_LO]),
        .period_max    (ed_per),
        .step_codes    (ed_step)
    );

    wire mute_req = ~soft_mute_pin_n | soft_mute_bit;
    wire down_req = mute_req | emergency;

    // emergency settings win over normal ones
    wire [1:0] down_int = emergency ?
                          emergency_volume_ramp_config[`DVR_EDF_HI:`DVR_EDF_LO] :
                          normal_volume_ramp_config[`DVR_NDF_HI:`DVR_NDF_LO];
    wire [2:0] down_per = emergency ? ed_per : nd_per;
    wire [7:0] down_stp = emergency ? ed_step : nd_step;
    wire [1:0] up_int   = normal_volume_ramp_config[`DVR_NUF_HI:`DVR_NUF_LO];

    // ramp arithmetic with headroom bit for clamping
    wire [8:0] down_sum = {1'b0, volume} + {1'b0, down_stp};
    wire [8:0] up_diff  = {1'b0, volume} - {1'b0, nu_step};
    wire       tick_due = fs_tick && (period_cnt == 3'h0);

    reg  [1:0]       next_state;
    reg  [VOL_W-1:0] next_volume;
    reg  [2:0]       next_period_cnt;

    always @*
    begin
        next_state      = state;
        next_volume     = volume;
        next_period_cnt = period_cnt;
        if (down_req)
        begin
            if (volume == `DVR_VOL_MUTE)
            begin
                next_state = ST_IDLE;
            end
            else if (down_int == `DVR_INT_INSTANT)
            begin
                next_volume = `DVR_VOL_MUTE;
                next_state  = ST_IDLE;
            end
            else
            begin
                next_state = ST_DOWN;
                if (state != ST_DOWN)
                begin
                    next_period_cnt = 3'h0;
                end
                else if (fs_tick)
                begin
                    next_period_cnt = tick_due ? down_per : period_cnt - 3'h1;
                    if (tick_due)
                    begin
                        // clamp to mute, passing -127 db
                        if (down_sum[8] || down_sum[7:0] > `DVR_VOL_MIN)
                            next_volume = `DVR_VOL_MUTE;
                        else
                            next_volume = down_sum[7:0];
                    end
                end
            end
        end
        else if (volume == target_volume)
        begin
            next_state = ST_IDLE;
        end
        else if (up_int == `DVR_INT_INSTANT)
        begin
            next_volume = target_volume;
            next_state  = ST_IDLE;
        end
        // above target (louder) moves straight down to it
        else if (volume < target_volume)
        begin
            next_volume = target_volume;
            next_state  = ST_IDLE;
        end
        else
        begin
            next_state = ST_UP;
            if (state != ST_UP)
            begin
                next_period_cnt = 3'h0;
            end
            else if (fs_tick)
            begin
                next_period_cnt = tick_due ? nu_per : period_cnt - 3'h1;
                if (tick_due)
                begin
                    if (volume == `DVR_VOL_MUTE)
                        next_volume = `DVR_VOL_MIN;
                    else if (up_diff[8] || up_diff[7:0] < target_volume)
                        next_volume = target_volume;
                    else
                        next_volume = up_diff[7:0];
                end
            end
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state      <= ST_IDLE;
            volume     <= `DVR_TARGET_RST;
            period_cnt <= 3'h0;
        end
        else
        begin
            state      <= next_state;
            volume     <= next_volume;
            period_cnt <= next_period_cnt;
        end
    end

    // register slave: one wait cycle, answer on second cycle
    wire req     = read | write;
    wire do_acc  = req & accessed;
    // only byte lane 0 carries writable register bits
    wire wr_hit  = do_acc & write & byteenable[0];
    wire mapped  = (address == `DVR_IDX_NORMAL) || (address == `DVR_IDX_EMERG) ||
                   (address == `DVR_IDX_CTRL) || (address == `DVR_IDX_STATUS) ||
                   (address == `DVR_IDX_TARGET);

    reg [31:0] next_readdata;

    always @*
    begin
        case (address)
            `DVR_IDX_NORMAL: next_readdata = {24'h0, normal_volume_ramp_config};
            `DVR_IDX_EMERG:  next_readdata = {24'h0, emergency_volume_ramp_config};
            `DVR_IDX_CTRL:   next_readdata = {31'h0, soft_mute_bit};
            `DVR_IDX_STATUS: next_readdata = {22'h0, state, volume};
            `DVR_IDX_TARGET: next_readdata = {24'h0, target_volume};
            default:         next_readdata = 32'h0;
        endcase
    end

    // bus handshake and read answer
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            accessed    <= 1'b0;
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
            response    <= RESP_OK;
        end
        else
        begin
            // waitrequest low in the cycle after a request is seen
            accessed    <= req & ~accessed;
            waitrequest <= ~(req & ~accessed);
            if (req & ~accessed)
            begin
                // unmapped reads return zero with an error code
                readdata <= read ? next_readdata : 32'h0;
                response <= mapped ? RESP_OK : RESP_ERR;
            end
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            normal_volume_ramp_config <= `DVR_NORMAL_RST;
        end
        else if (wr_hit && (address == `DVR_IDX_NORMAL))
        begin
            normal_volume_ramp_config <= writedata[7:0];
        end
    end

    // emergency settings, low nibble reads zero
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            emergency_volume_ramp_config <= `DVR_EMERG_RST;
        end
        else if (wr_hit && (address == `DVR_IDX_EMERG))
        begin
            emergency_volume_ramp_config <= {writedata[7:4], 4'h0};
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            soft_mute_bit <= 1'b0;
        end
        else if (wr_hit && (address == `DVR_IDX_CTRL))
        begin
            soft_mute_bit <= writedata[0];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            target_volume <= `DVR_TARGET_RST;
        end
        else if (wr_hit && (address == `DVR_IDX_TARGET))
        begin
            target_volume <= writedata[7:0];
        end
    end
endmodule // dvr_ramp

// ===== rtl/dvr_defs.vh
// constants for the digital volume ramp controller
// assumes a 50 MHz mclk and a 32-bit avalon-mm register port
`ifndef DVR_DEFS_VH
`define DVR_DEFS_VH

// register word addresses, as seen on the avalon address bus
`define DVR_IDX_NORMAL      8'h3f
`define DVR_IDX_EMERG       8'h40
`define DVR_IDX_CTRL        8'h80
`define DVR_IDX_STATUS      8'h81
`define DVR_IDX_TARGET      8'h82

// field positions
`define DVR_NDF_HI          7
`define DVR_NDF_LO          6
`define DVR_NDS_HI          5
`define DVR_NDS_LO          4
`define DVR_NUF_HI          3
`define DVR_NUF_LO          2
`define DVR_NUS_HI          1
`define DVR_NUS_LO          0
`define DVR_EDF_HI          7
`define DVR_EDF_LO          6
`define DVR_EDS_HI          5
`define DVR_EDS_LO          4

// reset values
`define DVR_NORMAL_RST      8'h33
`define DVR_EMERG_RST       8'h10
`define DVR_TARGET_RST      8'h30

// volume codes: 0.5 db per code, all ones is mute
`define DVR_VOL_MUTE        8'hff
`define DVR_VOL_MIN         8'hfe

// interval code meaning instant
`define DVR_INT_INSTANT     2'h3

`endif

// ===== rtl/dvr_step.v
// step size and interval decode for one ramp setting
// assumes 2-bit codes from the ramp configuration registers
module dvr_step
(
    // codes
    input  wire [1:0] interval_code,
    input  wire [1:0] step_code,
    // decoded
    output reg  [2:0] period_max,
    output reg  [7:0] step_codes
);
    always @*
    begin
        case (interval_code)
            2'h0:    period_max = 3'h0;
            2'h1:    period_max = 3'h1;
            2'h2:    period_max = 3'h3;
            default: period_max = 3'h0;
        endcase
        case (step_code)
            2'h0:    step_codes = 8'h08;
            2'h1:    step_codes = 8'h04;
            2'h2:    step_codes = 8'h02;
            default: step_codes = 8'h01;
        endcase
    end
endmodule // dvr_step

// ===== test/dvr_ramp_sva.sv
// assertions on the volume ramp block ports
// bound from the testbench top; one mclk domain
`include "dvr_defs.vh"
module dvr_ramp_sva
#(
    parameter VOL_W = 8
)
(
    // clock and reset
    input wire logic             mclk,
    input wire logic             rst,
    // register bus
    input wire logic [7:0]       address,
    input wire logic             read,
    input wire logic             write,
    input wire logic [31:0]      writedata,
    input wire logic [3:0]       byteenable,
    input wire logic [31:0]      readdata,
    input wire logic             waitrequest,
    input wire logic [1:0]       response,
    // audio side
    input wire logic             soft_mute_pin_n,
    input wire logic             emergency,
    input wire logic [VOL_W-1:0] volume
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
logic [1:0] ndf;
logic [1:0] edf;
wire        wr_ok  = write && !waitrequest && byteenable[0];
wire        req    = !soft_mute_pin_n || emergency;
wire        mapped = address inside {8'h3f, 8'h40, 8'h80, 8'h81, 8'h82};
// shadow copies of the down interval fields
always @(posedge mclk or posedge rst)
    if (rst)
        ndf <= 2'h0;
    else if (wr_ok && address == `DVR_IDX_NORMAL)
        ndf <= writedata[7:6];
always @(posedge mclk or posedge rst)
    if (rst)
        edf <= 2'h0;
    else if (wr_ok && address == `DVR_IDX_EMERG)
        edf <= writedata[7:6];
sequence s_req;
    (read || write) && waitrequest;
endsequence
sequence s_rd_ack;
    read && !waitrequest;
endsequence
property p_ack; s_req |=> !waitrequest; endproperty
a_ack: assert property (p_ack) else $error("request not answered");
property p_ack_one; !waitrequest |=> waitrequest; endproperty
a_ack_one: assert property (p_ack_one) else $error("ack too long");
property p_resp;
    s_rd_ack |-> (mapped ? response == 2'h0 : response == 2'h2 && readdata == 32'h0);
endproperty
a_resp: assert property (p_resp) else $error("bad read response");
property p_dn_mono; req |=> volume >= $past(volume); endproperty
a_dn_mono: assert property (p_dn_mono) else $error("louder while muting");
property p_dn_step; req |=> volume == 8'hff || volume - $past(volume) <= 8'h8; endproperty
a_dn_step: assert property (p_dn_step) else $error("down step too big");
property p_inst_dn; !soft_mute_pin_n && !emergency && ndf == 2'h3 |-> ##[1:2] volume == 8'hff;
endproperty
a_inst_dn: assert property (p_inst_dn) else $error("no instant mute");
property p_inst_em; emergency && edf == 2'h3 |-> ##[1:2] volume == 8'hff; endproperty
a_inst_em: assert property (p_inst_em) else $error("no instant emergency mute");
property p_hold; req && volume == 8'hff |=> volume == 8'hff; endproperty
a_hold: assert property (p_hold) else $error("left mute while requested");
endmodule // dvr_ramp_sva

// ===== test/test_dvr_ramp.sv
// self-checking bench for the volume ramp block
// drives bus, pin, emergency and fs_tick; checker bound below
module test_dvr_ramp;
timeunit 1ns;
timeprecision 1ps;
logic        mclk = 0, rst = 1, read = 0, write = 0, fs_tick = 0;
logic        soft_mute_pin_n = 1, emergency = 0;
logic [7:0]  address = 8'h0, cur, tgt;
logic [31:0] writedata = 32'h0;
logic [3:0]  byteenable = 4'hf;
logic [1:0]  iv, sc;
wire  [31:0] readdata;
wire         waitrequest;
wire  [1:0]  response;
wire  [7:0]  volume;
logic [33:0] exp_rd[$];
logic [7:0]  exp_vol[$], vol_q;
int          error_cnt = 0, n_compared = 0, cyc = 0, seed = 32'h3d6c62cb;
int          per, st, n, k, src;
always #10 mclk = ~mclk;
dvr_ramp u_dvr_ramp (.mclk, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .response, .fs_tick, .soft_mute_pin_n, .emergency, .volume);
task bad(input logic [63:0] g, e);
    error_cnt++;
    $display("BAD t=%0t got %h exp %h", $time, g, e);
endtask
task chk_rd(input logic [33:0] g, e);
    n_compared++;
    if (g !== e)
        bad(g, e);
endtask
task chk_vol(input logic [7:0] g, e);
    n_compared++;
    if (g !== e)
        bad(g, e);
endtask
task chk_cnt(input int g, e);
    n_compared++;
    if (g != e)
        bad(g, e);
endtask
task final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// hold the request until waitrequest is sampled low
task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
        @(posedge mclk);
    read <= 0;
    write <= 0;
    @(posedge mclk);
endtask
task rd(input logic [7:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    bus(0, a, 32'h0);
endtask
task ramp;
    int j;
    repeat (4) @(posedge mclk);
    for (j = 0; iv != 2'h3 && j < per * n; j++)
    begin
        fs_tick <= 1;
        @(posedge mclk);
        fs_tick <= 0;
        repeat (2) @(posedge mclk);
        chk_cnt(exp_vol.size(), n - j / per - 1);
    end
    chk_cnt(exp_vol.size(), 0);
endtask
// result watcher: read answers and every volume change
always @(posedge mclk)
begin
    if (read && waitrequest === 1'b0)
        chk_rd({response, readdata}, exp_rd.pop_front());
    if (!rst && volume !== vol_q)
        chk_vol(volume, exp_vol.size() ? exp_vol.pop_front() : 8'hxx);
    vol_q <= volume;
    cyc++;
    if (cyc == 60000)
    begin
        error_cnt++;
        final_report;
    end
end
initial
begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    rd(8'h3f, {26'h0, 8'h33});
    rd(8'h82, {26'h0, 8'h30});
    rd(8'h55, {2'h2, 32'h0});
    cur = 8'h30;
    for (k = 0; k < 16; k++)
    begin
        iv = k[1:0];
        sc = k[3:2];
        per = 1 << iv;
        st = 8 >> sc;
        src = k % 3;
        bus(1, 8'h3f, {24'h0, src == 1 ? ~{iv, sc} : {iv, sc}, iv, sc});
        bus(1, 8'h40, {24'h0, iv, sc, 4'hf});
        rd(8'h40, {26'h0, iv, sc, 4'h0});
        n = 0;
        while (cur !== 8'hff)
        begin
            cur = (iv == 2'h3 || cur + st > 254) ? 8'hff : cur + st;
            exp_vol.push_back(cur);
            n++;
        end
        if (src == 0)
            soft_mute_pin_n <= 0;
        else if (src == 1)
            emergency <= 1;
        else
            bus(1, 8'h80, 32'h1);
        ramp;
        tgt = 8'($random(seed));
        if (tgt == 8'hff)
            tgt = 8'hfe;
        bus(1, 8'h82, {24'h0, tgt});
        n = 0;
        while (cur !== tgt)
        begin
            cur = (iv == 2'h3) ? tgt : (cur == 8'hff) ? 8'hfe
                : (cur < tgt + st) ? tgt : cur - st;
            exp_vol.push_back(cur);
            n++;
        end
        soft_mute_pin_n <= 1;
        emergency <= 0;
        if (src == 2)
            bus(1, 8'h80, 32'h0);
        ramp;
        rd(8'h81, {26'h0, tgt});
        $display("ramp test %0d done", k);
    end
    // write with byte lane 0 off must leave the settings alone
    byteenable <= 4'he;
    bus(1, 8'h3f, 32'h0);
    byteenable <= 4'hf;
    rd(8'h3f, {26'h0, 8'hff});
    // quieter target than the current code: volume goes there at once
    tgt = cur + 8'h01;
    exp_vol.push_back(tgt);
    bus(1, 8'h82, {24'h0, tgt});
    repeat (3) @(posedge mclk);
    chk_cnt(exp_vol.size(), 0);
    rd(8'h81, {26'h0, tgt});
    $display("jump and lane test done");
    final_report;
end
endmodule // test_dvr_ramp
bind dvr_ramp dvr_ramp_sva #(.VOL_W(VOL_W)) u_dvr_ramp_sva (.mclk, .rst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .response, .soft_mute_pin_n,
    .emergency, .volume);
